/* verilog/crtro_pkg.sv */
package crtro_pkg;

  // Clock and timing
  localparam int CLK_HZ = 100_000_000;
  localparam int OFF_TIME_US = 140;
  localparam int OFF_CYCLES = OFF_TIME_US * (CLK_HZ / 1_000_000);
  localparam int DOT_HOLD_CYCLES = 3;

  // Scan geometry
  localparam int COLS = 8;
  localparam int ROWS = 8;
  localparam int CHARS_PER_LINE = 40;
  localparam int LINES = 16;
  localparam int BLANK_COLS = 3;
  localparam int BLANK_ROWS = 1;
  localparam int SPECTRUM_MAX_LINES = 3;

  // Character word layout
  localparam int CHAR_W = 8;
  localparam int BLANK_BIT = 7;
  localparam int GLYPH_W = 64;

  // Control port layout
  localparam int CTRL_ENABLE_BIT = 0;
  localparam logic [7:0] CTRL_RESET = 8'h00;

  // LFSR seed for the interleave randomiser
  localparam logic [7:0] LFSR_SEED = 8'hA5;
  localparam logic [7:0] LFSR_TAPS = 8'hB8;

  typedef enum logic [1:0] {
    CRTRO_IDLE = 2'b00,
    CRTRO_OFF = 2'b01,
    CRTRO_RUN = 2'b11,
    CRTRO_DOT = 2'b10
  } crtro_state_e;

  // Scan position travelling together
  typedef struct packed {
    logic [3:0] line;
    logic [5:0] chr;
    logic [2:0] row;
    logic [2:0] col;
  } crtro_pos_s;

  // Beam drive outputs travelling together
  typedef struct packed {
    logic readoutOff;
    logic unblank;
    logic beamEnable;
    logic spectrumInhibit;
  } crtro_beam_s;

endpackage

/* verilog/crtro_off_timer.sv */
`timescale 1ns/1ps
module crtro_off_timer #(
  parameter int CYCLES = 14000
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic start,
  input wire logic [3:0] jitter,
  output logic expired,
  output logic busy
);
  import crtro_pkg::*;

  logic [15:0] count;

  // Off interval count; a small random extension moves trace gaps
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      count <= 16'h0000;
      busy <= 1'b0;
      expired <= 1'b0;
    end else if (start) begin
      count <= 16'(CYCLES) + 16'(jitter);
      busy <= 1'b1;
      expired <= 1'b0;
    end else if (busy && count <= 16'h0001) begin
      busy <= 1'b0;
      expired <= 1'b1;
    end else begin
      if (busy) begin
        count <= count - 16'h0001;
      end
      expired <= 1'b0;
    end
  end

endmodule

/* verilog/crtro_sequencer.sv */
`timescale 1ns/1ps
module crtro_sequencer #(
  parameter int OFF_CNT = crtro_pkg::OFF_CYCLES,
  parameter int MAX_LINES = crtro_pkg::LINES
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic [3:0] addr,
  input wire logic [7:0] wrData,
  input wire logic wrStrobe,
  input wire logic rdStrobe,
  output logic [7:0] rdData,
  input wire logic [crtro_pkg::CHAR_W-1:0] charData,
  input wire logic [crtro_pkg::GLYPH_W-1:0] glyph,
  output crtro_pkg::crtro_pos_s scanPos,
  output crtro_pkg::crtro_beam_s beam,
  output logic char_gen_active
);
  import crtro_pkg::*;

  // Register map
  localparam logic [3:0] ADDR_CTRL = 4'h0;
  localparam logic [3:0] ADDR_LINES = 4'h1;
  localparam logic [3:0] ADDR_STATUS = 4'h2;
  localparam logic [3:0] ADDR_POSLO = 4'h3;

  // Software-visible settings
  logic readoutEnable;
  logic [3:0] lastLine;
  logic ctrlWrite;
  logic linesWrite;
  logic [7:0] rdWord;

  // Generator and scan state
  crtro_state_e state;
  crtro_pos_s pos;
  logic [1:0] holdCnt;
  logic holdLit;
  logic holdDone;

  // Off interval timer handshake and its random source
  logic [7:0] lfsr;
  logic timerStart;
  logic timerExpired;
  logic timerBusy;

  // Cell decode for the current scan position
  logic scan_advance;
  logic lastCell;
  logic dotLit;
  logic blankChar;
  logic [5:0] glyphIdx;

  // Pixel index within the 64-bit glyph; row-major
  function automatic logic [5:0] cellIndex(input logic [2:0] r,
                                            input logic [2:0] c);
    cellIndex = {r, c};
  endfunction

  // Dot only inside the visible 7x5 area of the cell
  function automatic logic visibleCell(input logic [2:0] r,
                                       input logic [2:0] c);
    visibleCell = (32'(r) >= BLANK_ROWS) && (32'(c) >= BLANK_COLS);
  endfunction

  // Bottom right cell closes the character scan
  function automatic logic isLastCell(input logic [2:0] r,
                                      input logic [2:0] c);
    isLastCell = (r == 3'(ROWS - 1)) && (c == 3'(COLS - 1));
  endfunction

  // Generator owns the beam in the run and dot-hold states
  function automatic logic isActive(input crtro_state_e s);
    isActive = (s == CRTRO_RUN) || (s == CRTRO_DOT);
  endfunction

  // Character index wraps after the last position of a line
  function automatic logic [5:0] nextChr(input logic [5:0] c);
    if (c == 6'(CHARS_PER_LINE - 1)) begin
      nextChr = 6'h00;
    end else begin
      nextChr = c + 6'h01;
    end
  endfunction

  // Line index wraps at the programmed last line or the hard limit
  function automatic logic [3:0] nextLine(input logic [3:0] l,
                                          input logic [3:0] last);
    if (l >= last || 32'(l) >= MAX_LINES - 1) begin
      nextLine = 4'h0;
    end else begin
      nextLine = l + 4'h1;
    end
  endfunction

  // More than three lines shown leaves no room for the trace
  function automatic logic tooManyLines(input logic [3:0] last);
    tooManyLines = 32'(last) + 1 > SPECTRUM_MAX_LINES;
  endfunction

  // One step of the Galois shift register
  function automatic logic [7:0] lfsrStep(input logic [7:0] s);
    lfsrStep = s[0] ? ((s >> 1) ^ LFSR_TAPS) : (s >> 1);
  endfunction

  assign glyphIdx = cellIndex(pos.row, pos.col);
  assign blankChar = charData[BLANK_BIT];
  assign dotLit = (state == CRTRO_RUN) && !blankChar &&
                  visibleCell(pos.row, pos.col) && glyph[glyphIdx];
  assign holdLit = (state == CRTRO_DOT) && (holdCnt != 2'h0);
  assign holdDone = (state == CRTRO_DOT) && (holdCnt == 2'h0);
  // Leaving a dot hold moves on one cell, so the same dot is not lit again
  assign scan_advance = ((state == CRTRO_RUN) && !dotLit) || holdDone;
  assign lastCell = isLastCell(pos.row, pos.col);

  // Write decode; unmapped addresses are ignored
  assign ctrlWrite = wrStrobe && (addr == ADDR_CTRL);
  assign linesWrite = wrStrobe && (addr == ADDR_LINES);

  // Readout enable; nothing is drawn until software sets it
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      readoutEnable <= CTRL_RESET[CTRL_ENABLE_BIT];
    end else if (ctrlWrite) begin
      readoutEnable <= wrData[CTRL_ENABLE_BIT];
    end
  end

  // Last line shown; two lines after reset
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      lastLine <= 4'h1;
    end else if (linesWrite) begin
      lastLine <= wrData[3:0];
    end
  end

  // Readback word for the addressed register; unmapped reads zero
  always_comb begin
    rdWord = 8'h00;
    unique case (addr)
      ADDR_CTRL: rdWord = {7'h00, readoutEnable};
      ADDR_LINES: rdWord = {4'h0, lastLine};
      ADDR_STATUS: rdWord = {4'h0, timerBusy, beam.spectrumInhibit, state};
      ADDR_POSLO: rdWord = {2'h0, pos.chr};
      default: rdWord = 8'h00;
    endcase
  end

  // Read data stands one cycle after the strobe and is zero otherwise
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      rdData <= 8'h00;
    end else if (rdStrobe) begin
      rdData <= rdWord;
    end else begin
      rdData <= 8'h00;
    end
  end

  // Pseudorandom source for interleave jitter
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      lfsr <= LFSR_SEED;
    end else begin
      lfsr <= lfsrStep(lfsr);
    end
  end

  // Off interval one-shot; restarted at the end of every character
  crtro_off_timer #(
    .CYCLES(OFF_CNT)
  ) offTimer (
    .ref_clk(ref_clk),
    .rst(rst),
    .start(timerStart),
    .jitter(lfsr[3:0]),
    .expired(timerExpired),
    .busy(timerBusy)
  );

  // Dot hold counter; loaded as a lit dot is met, then counts down
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      holdCnt <= 2'h0;
    end else if (dotLit) begin
      holdCnt <= 2'(DOT_HOLD_CYCLES - 1);
    end else if (holdLit) begin
      holdCnt <= holdCnt - 2'h1;
    end
  end

  // Generator state; one character per active interval
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      state <= CRTRO_IDLE;
      timerStart <= 1'b0;
    end else begin
      timerStart <= 1'b0;
      if (!readoutEnable) begin
        state <= CRTRO_IDLE;
      end else begin
        unique case (state)
          CRTRO_IDLE: begin
            state <= CRTRO_OFF;
            timerStart <= 1'b1;
          end
          CRTRO_OFF: begin
            if (timerExpired) begin
              state <= CRTRO_RUN;
            end
          end
          CRTRO_RUN: begin
            if (blankChar) begin
              // Blank characters skip straight back to row 0 col 0
              state <= CRTRO_OFF;
              timerStart <= 1'b1;
            end else if (dotLit) begin
              state <= CRTRO_DOT;
            end else if (lastCell) begin
              // Reaching the last cell wraps the scan to row 0 col 0
              state <= CRTRO_OFF;
              timerStart <= 1'b1;
            end
          end
          CRTRO_DOT: begin
            if (holdDone && lastCell) begin
              // A lit last cell still gets its full hold first
              state <= CRTRO_OFF;
              timerStart <= 1'b1;
            end else if (holdDone) begin
              state <= CRTRO_RUN;
            end
          end
        endcase
      end
    end
  end

  // Scan counters; the dot hold stops them
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      pos <= '0;
    end else if (scan_advance) begin
      if (blankChar || lastCell) begin
        pos.row <= 3'h0;
        pos.col <= 3'h0;
        pos.chr <= nextChr(pos.chr);
        if (pos.chr == 6'(CHARS_PER_LINE - 1)) begin
          pos.line <= nextLine(pos.line, lastLine);
        end
      end else if (pos.col == 3'(COLS - 1)) begin
        pos.col <= 3'h0;
        pos.row <= pos.row + 3'h1;
      end else begin
        pos.col <= pos.col + 3'h1;
      end
    end
  end

  // Generator flag and scan position to the pins, both registered
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      char_gen_active <= 1'b0;
      scanPos <= '0;
    end else begin
      char_gen_active <= isActive(state);
      scanPos <= pos;
    end
  end

  // Beam drive; registered so the deflection sees clean levels
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      beam.readoutOff <= 1'b1;
      beam.unblank <= 1'b0;
      beam.beamEnable <= 1'b0;
      beam.spectrumInhibit <= 1'b0;
    end else begin
      beam.readoutOff <= !(isActive(state) && !blankChar);
      beam.unblank <= dotLit || holdLit;
      beam.beamEnable <= (dotLit || holdLit) && !blankChar;
      beam.spectrumInhibit <= readoutEnable && tooManyLines(lastLine);
    end
  end

endmodule

/* testbench/crtro_seq_asserts.sv */
`timescale 1ns/1ps
module crtro_seq_asserts #(
  parameter int OFF_CNT = 20
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic [3:0] addr,
  input wire logic [7:0] wrData,
  input wire logic wrStrobe,
  input wire logic rdStrobe,
  input wire logic [7:0] rdData,
  input wire crtro_pkg::crtro_pos_s scanPos,
  input wire crtro_pkg::crtro_beam_s beam,
  input wire logic char_gen_active
);
  import crtro_pkg::*;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  logic en;
  int gap;
  // Shadow of the enable bit, so every start can be tied to software
  always_ff @(posedge ref_clk) begin
    if (rst) en <= 1'b0;
    else if (wrStrobe && addr == 4'h0) en <= wrData[0];
  end
  // Idle cycles since the generator last ran
  always_ff @(posedge ref_clk) begin
    if (rst || char_gen_active) gap <= 0;
    else gap <= gap + 1;
  end
  sequence lit_hold_s;
    beam.unblank [*3];
  endsequence
  beam_gate_a: assert property (beam.beamEnable |->
    beam.unblank && !beam.readoutOff) else $error("beam on while gated");
  dot_hold_a: assert property ($rose(beam.unblank) |->
    lit_hold_s) else $error("lit dot shorter than three cycles");
  blank_cell_a: assert property (beam.unblank |->
    scanPos.col >= 3'h3 && scanPos.row != 3'h0) else $error("dot in margin");
  chr_range_a: assert property (scanPos.chr < 6'h28)
    else $error("character count past forty");
  start_en_a: assert property ($rose(char_gen_active) |-> en)
    else $error("generator started while readout off");
  off_gap_a: assert property ($rose(char_gen_active) |->
    gap >= OFF_CNT - 1) else $error("off interval too short");
  deselect_a: assert property (!beam.readoutOff |->
    char_gen_active || $past(char_gen_active)) else $error("stray select");
  rd_idle_a: assert property (!$past(rdStrobe) |-> rdData == 8'h00)
    else $error("read data outside its cycle");
  reset_out_a: assert property ($fell(rst) |->
    beam.readoutOff && !char_gen_active) else $error("bad reset state");
endmodule

/* testbench/crtro_char_store.sv */
`timescale 1ns/1ps
module crtro_char_store (
  input wire crtro_pkg::crtro_pos_s scanPos,
  output logic [crtro_pkg::CHAR_W-1:0] charData,
  output logic [crtro_pkg::GLYPH_W-1:0] glyph
);
  import crtro_pkg::*;
  // Every fifth character holds a space; glyphs light margin dots on purpose
  always_comb begin
    charData = {scanPos.chr % 5 == 0,
      scanPos.chr[4:0] ^ {1'b0, scanPos.line}, 2'b01};
    glyph = {8{charData}};
  end
endmodule

/* testbench/testbench.sv */
`timescale 1ns/1ps
module testbench;
  import crtro_pkg::*;
  localparam int OFFN = 20;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic [3:0] addr = 4'h0;
  logic [7:0] wrData = 8'h00;
  logic wrStrobe = 1'b0;
  logic rdStrobe = 1'b0;
  logic [7:0] rdData, charData, v, r;
  logic [63:0] glyph;
  crtro_pos_s scanPos;
  crtro_beam_s beam;
  logic char_gen_active;
  int errorCnt = 0;
  int nTests = 0;
  int n, lo, hi;
  initial forever #5 ref_clk = ~ref_clk;
  crtro_sequencer #(.OFF_CNT(OFFN)) i_crtro_sequencer (.ref_clk(ref_clk),
    .rst(rst), .addr(addr), .wrData(wrData), .wrStrobe(wrStrobe),
    .rdStrobe(rdStrobe), .rdData(rdData), .charData(charData),
    .glyph(glyph), .scanPos(scanPos), .beam(beam),
    .char_gen_active(char_gen_active));
  crtro_char_store i_crtro_char_store (.scanPos(scanPos),
    .charData(charData), .glyph(glyph));
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    nTests++;
    if (seen !== exp) begin
      errorCnt++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic closeOut;
    $display("comparisons=%0d mismatches=%0d", nTests, errorCnt);
    if (errorCnt == 0 && nTests > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    addr <= a;
    wrData <= d;
    wrStrobe <= 1'b1;
    @(posedge ref_clk);
    wrStrobe <= 1'b0;
  endtask
  // Read data is looked at only in the cycle after the strobe
  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge ref_clk);
    addr <= a;
    rdStrobe <= 1'b1;
    @(posedge ref_clk);
    rdStrobe <= 1'b0;
    #1 d = rdData;
  endtask
  // Bounded wait for the generator to reach a level
  task automatic waitAct(input logic lvl, input int lim, output int cnt);
    cnt = 0;
    while (char_gen_active !== lvl) begin
      @(posedge ref_clk);
      #1;
      cnt++;
      if (cnt > lim) begin
        errorCnt++;
        closeOut();
      end
    end
  endtask
  initial begin
    void'($urandom(32'heaec));
    repeat (12) @(posedge ref_clk);
    rst <= 1'b0;
    #1;
    chk(beam.readoutOff, 1);
    chk(char_gen_active, 0);
    rd(4'h1, v);
    chk(v, 8'h01);
    repeat (OFFN + 40) @(posedge ref_clk);
    chk(char_gen_active, 0);
    $display("reset and idle test done");
    wr(4'h0, 8'h01);
    rd(4'h0, v);
    chk(v, 8'h01);
    waitAct(1'b1, OFFN + 24, n);
    lo = 999;
    hi = 0;
    // Off gaps are timed from the fall of the active flag
    for (int i = 0; i < 12; i++) begin
      waitAct(1'b0, 600, n);
      waitAct(1'b1, OFFN + 24, n);
      chk(n >= OFFN - 1, 1);
      lo = (n < lo) ? n : lo;
      hi = (n > hi) ? n : hi;
    end
    chk(hi != lo, 1);
    $display("character timing test done");
    // Fixed last-line values 0, 5, 10 and 15 first, then random ones
    for (int i = 0; i < 8; i++) begin
      v = (i < 4) ? 8'(i * 5 % 16) : 8'($urandom_range(15, 0));
      wr(4'h1, v);
      rd(4'h2, r);
      chk(r[2], v >= 3);
      chk(beam.spectrumInhibit, v >= 3);
      rd(4'h1, r);
      chk(r, v);
    end
    for (int i = 0; i < 4; i++) begin
      v = 8'(4 + $urandom_range(11, 0));
      wr(v[3:0], 8'($urandom));
      rd(v[3:0], r);
      chk(r, 8'h00);
    end
    $display("register test done");
    wr(4'h0, 8'h00);
    waitAct(1'b0, 600, n);
    repeat (OFFN + 40) @(posedge ref_clk);
    chk(char_gen_active, 0);
    $display("disable test done");
    closeOut();
  end
endmodule
bind crtro_sequencer crtro_seq_asserts #(.OFF_CNT(OFF_CNT)) u_chk (
  .ref_clk(ref_clk), .rst(rst), .addr(addr), .wrData(wrData),
  .wrStrobe(wrStrobe), .rdStrobe(rdStrobe), .rdData(rdData),
  .scanPos(scanPos), .beam(beam), .char_gen_active(char_gen_active));
